/* File: src/lpd_ctrl.v */
// low-power debug control: voltage select, debug modes, freezes
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lpd_consts.vh"
module lpd_ctrl (
  input wire mclk, // 250 MHz clock
  input wire rst_n, // power-on/down reset, active low
  input wire sys_rst_n, // system reset, leaves these regs alone
  input wire [5:0] reg_addr, // byte address
  input wire [31:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [31:0] reg_rdata, // read data, cycle after strobe
  input wire debugger_attached, // async, debugger connected
  input wire core_halted, // core in debug state
  input wire sleep_req, // sleep entry request
  input wire stop_req, // stop entry request
  input wire pd_req, // powerdown entry request
  input wire in_stop, // chip currently in stop
  output reg [1:0] core_voltage_sel, // 01: 1.5V, 11: 1.2V
  output reg adv_timer_b_debug_freeze, // freeze advanced timer b
  output reg basic_timer_debug_freeze, // freeze basic timer
  output reg lowpower_timer_debug_freeze, // freeze low-power timer
  output reg second_smbus_timeout_freeze, // freeze smbus 2 timeout
  output reg first_smbus_timeout_freeze, // freeze smbus 1 timeout
  output reg general_timer_debug_freeze, // freeze general timer
  output reg adv_timer_a_debug_freeze, // freeze advanced timer a
  output reg window_watchdog_debug_freeze, // freeze window watchdog
  output reg independent_watchdog_debug_freeze, // freeze indep watchdog
  output wire core_clk_en, // free-running clock enable
  output wire bus_clk_en, // bus clock enable
  output wire clk_src_rc, // free-running from rc osc
  output wire logic_power_on // core digital supply on
);
  reg [1:0] vsel_q;
  reg [1:0] vovr_q;
  reg [31:0] dbg_q;
  reg pd_flag_q;
  wire dbg_ok;
  wire pd_pulse;
  wire clr_flag;
  localparam [31:0] vsel_rst = `LPD_VSEL_RST;
  localparam [31:0] vovr_rst = `LPD_VOVR_RST;
  // ************
  // input sync
  // ************
  lpd_sync3 u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(debugger_attached),
    .dout(dbg_ok)
  );
  // ************
  // registers
  // ************
  assign clr_flag = reg_wr && reg_addr == `LPD_OFF_STAT && reg_wdata[1];
  // sys_rst_n intentionally unused: only power reset clears these
  always @(posedge mclk) begin
    if (!rst_n) begin
      vsel_q <= vsel_rst[`LPD_VSEL_HI:`LPD_VSEL_LO];
      vovr_q <= vovr_rst[`LPD_VSEL_HI:`LPD_VSEL_LO];
      dbg_q <= `LPD_DBG_RST;
      pd_flag_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `LPD_OFF_VSEL) begin
        vsel_q <= reg_wdata[`LPD_VSEL_HI:`LPD_VSEL_LO];
      end else if (reg_wr && reg_addr == `LPD_OFF_VOVR) begin
        vovr_q <= reg_wdata[`LPD_VSEL_HI:`LPD_VSEL_LO];
      end else if (reg_wr && reg_addr == `LPD_OFF_DBG && dbg_ok) begin
        dbg_q <= reg_wdata & (`LPD_DBG_MASK | `LPD_DBG_MASK_PD);
      end
      if (pd_pulse) begin
        pd_flag_q <= 1'b1;
      end else if (clr_flag) begin
        pd_flag_q <= 1'b0;
      end
    end
  end
  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == `LPD_OFF_VSEL) begin
        reg_rdata <= {28'h0000000, vsel_q, 2'h3};
      end else if (reg_addr == `LPD_OFF_VOVR) begin
        reg_rdata <= {28'h0000000, vovr_q, 2'h0};
      end else if (reg_addr == `LPD_OFF_DBG) begin
        reg_rdata <= dbg_q;
      end else if (reg_addr == `LPD_OFF_STAT) begin
        reg_rdata <= {30'h00000000, pd_flag_q, 1'b0};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
  // ************
  // voltage and freezes
  // ************
  always @(posedge mclk) begin
    if (!rst_n) begin
      core_voltage_sel <= `LPD_V1P5;
      adv_timer_b_debug_freeze <= 1'b0;
      basic_timer_debug_freeze <= 1'b0;
      lowpower_timer_debug_freeze <= 1'b0;
      second_smbus_timeout_freeze <= 1'b0;
      first_smbus_timeout_freeze <= 1'b0;
      general_timer_debug_freeze <= 1'b0;
      adv_timer_a_debug_freeze <= 1'b0;
      window_watchdog_debug_freeze <= 1'b0;
      independent_watchdog_debug_freeze <= 1'b0;
    end else begin
      // 01 is 1.5V, 11 is 1.2V
      if (in_stop && vovr_q == `LPD_OVR_ON && vsel_q == `LPD_V1P2) begin
        core_voltage_sel <= `LPD_V1P2;
      end else begin
        core_voltage_sel <= `LPD_V1P5;
      end
      adv_timer_b_debug_freeze <= dbg_q[20] & core_halted;
      basic_timer_debug_freeze <= dbg_q[18] & core_halted;
      lowpower_timer_debug_freeze <= dbg_q[17] & core_halted;
      second_smbus_timeout_freeze <= dbg_q[16] & core_halted;
      first_smbus_timeout_freeze <= dbg_q[15] & core_halted;
      general_timer_debug_freeze <= dbg_q[12] & core_halted;
      adv_timer_a_debug_freeze <= dbg_q[10] & core_halted;
      window_watchdog_debug_freeze <= dbg_q[9] & core_halted;
      independent_watchdog_debug_freeze <= dbg_q[8] & core_halted;
    end
  end
  // ************
  // low-power clock modes
  // ************
  lpd_clkmode u_mode (
    .mclk(mclk),
    .rst_n(rst_n),
    .sleep_req(sleep_req),
    .stop_req(stop_req),
    .pd_req(pd_req),
    .dbg_mode(dbg_q[2:0]),
    .core_clk_en(core_clk_en),
    .bus_clk_en(bus_clk_en),
    .clk_src_rc(clk_src_rc),
    .logic_power_on(logic_power_on),
    .dbg_pd_enter(pd_pulse)
  );
endmodule // lpd_ctrl
`default_nettype wire

/* File: pkg/lpd_consts.vh */
// constants for the low-power debug control block
// How it works
// - stop voltage select bits 3:2 pick level
// - override 00 keeps 1.5V, 11 uses select
// - voltage fields reset only by power reset
// - debug register resets only by power reset
// - debug register writable only with debugger
// - bits 20,18,17 freeze timers in debug
// - bits 12,10 freeze timers in debug
// - bits 9,8 freeze watchdogs in debug
// - bits 16,15 freeze smbus timeouts
// - powerdown bit clear: clocks off, unpowered
// - powerdown bit set: debug powerdown, clocks run
// - stop bit clear: all clocks off, rc selected during stop
// - stop bit set: clocks run from rc
// - sleep bit clear: bus clock off only
// - sleep bit set: both clocks keep running
// - debug powerdown entry sets sticky flag
`ifndef LPD_CONSTS_VH
`define LPD_CONSTS_VH
`define LPD_OFF_VSEL 6'h24
`define LPD_OFF_VOVR 6'h28
`define LPD_OFF_DBG 6'h30
`define LPD_OFF_STAT 6'h34
`define LPD_VSEL_RST 32'h00000007
`define LPD_VOVR_RST 32'h00000000
`define LPD_DBG_RST 32'h00000000
`define LPD_DBG_MASK 32'h00179703
`define LPD_DBG_MASK_PD 32'h00000004
`define LPD_BIT_SLEEP 0
`define LPD_BIT_STOP 1
`define LPD_BIT_PD 2
`define LPD_VSEL_LO 2
`define LPD_VSEL_HI 3
`define LPD_V1P5 2'h1
`define LPD_V1P2 2'h3
`define LPD_OVR_ON 2'h3
`define LPD_OVR_OFF 2'h0
`endif

/* File: src/lpd_sync3.v */
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module lpd_sync3 (
  input wire mclk, // clock
  input wire rst_n, // sync reset
  input wire din, // async input
  output reg dout // filtered level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge mclk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // lpd_sync3
`default_nettype wire

/* File: src/lpd_clkmode.v */
// clock and supply mode decode for low-power states
`timescale 1ns/100ps
`default_nettype none
`include "lpd_consts.vh"
module lpd_clkmode (
  input wire mclk, // clock
  input wire rst_n, // sync reset
  input wire sleep_req, // sleep request
  input wire stop_req, // stop request
  input wire pd_req, // powerdown request
  input wire [2:0] dbg_mode, // sleep/stop/pd debug bits
  output reg core_clk_en, // free-running clock enable
  output reg bus_clk_en, // bus clock enable
  output reg clk_src_rc, // 1: free-running from rc osc
  output reg logic_power_on, // core digital supply on
  output reg dbg_pd_enter // one pulse on debug pd entry
);
  // set while debug pd was held last cycle, so every entry pulses once
  reg dbg_pd_q;
  always @(posedge mclk) begin
    if (!rst_n) begin
      dbg_pd_q <= 1'b0;
      core_clk_en <= 1'b1;
      bus_clk_en <= 1'b1;
      clk_src_rc <= 1'b0;
      logic_power_on <= 1'b1;
      dbg_pd_enter <= 1'b0;
    end else begin
      dbg_pd_q <= 1'b0;
      dbg_pd_enter <= 1'b0;
      core_clk_en <= 1'b1;
      bus_clk_en <= 1'b1;
      clk_src_rc <= 1'b0;
      logic_power_on <= 1'b1;
      if (pd_req) begin
        if (dbg_mode[`LPD_BIT_PD]) begin
          clk_src_rc <= 1'b1;
          dbg_pd_q <= 1'b1;
          dbg_pd_enter <= ~dbg_pd_q;
        end else begin
          core_clk_en <= 1'b0;
          bus_clk_en <= 1'b0;
          logic_power_on <= 1'b0;
        end
      end else if (stop_req) begin
        if (dbg_mode[`LPD_BIT_STOP]) begin
          clk_src_rc <= 1'b1;
        end else begin
          core_clk_en <= 1'b0;
          bus_clk_en <= 1'b0;
          clk_src_rc <= 1'b1;
        end
      end else if (sleep_req) begin
        bus_clk_en <= dbg_mode[`LPD_BIT_SLEEP];
      end
    end
  end
endmodule // lpd_clkmode
`default_nettype wire

/* File: sim/lpd_ctrl_chk.sv */
// checker for the low-power debug control block
`timescale 1ns/100ps
`default_nettype none
module lpd_ctrl_chk (
  input wire mclk, // clock
  input wire rst_n, // power reset
  input wire core_halted, // core halted
  input wire sleep_req, // sleep request
  input wire stop_req, // stop request
  input wire pd_req, // pd request
  input wire in_stop, // in stop
  input wire [1:0] core_voltage_sel, // voltage code
  input wire adv_timer_b_debug_freeze, // freeze
  input wire basic_timer_debug_freeze, // freeze
  input wire lowpower_timer_debug_freeze, // freeze
  input wire second_smbus_timeout_freeze, // freeze
  input wire first_smbus_timeout_freeze, // freeze
  input wire general_timer_debug_freeze, // freeze
  input wire adv_timer_a_debug_freeze, // freeze
  input wire window_watchdog_debug_freeze, // freeze
  input wire independent_watchdog_debug_freeze, // freeze
  input wire core_clk_en, // core clock on
  input wire bus_clk_en, // bus clock on
  input wire clk_src_rc, // rc source
  input wire logic_power_on // supply on
);
  // ***************
  // properties
  // ***************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  volt_code_legal_a: assert property (core_voltage_sel == 2'h1 || core_voltage_sel == 2'h3)
    else $error("reserved voltage code driven");
  volt_run_a: assert property (!$past(in_stop) |-> core_voltage_sel == 2'h1)
    else $error("voltage not 1.5V outside stop");
  freeze_gate_a: assert property (!$past(core_halted) |-> {adv_timer_b_debug_freeze,
    basic_timer_debug_freeze, lowpower_timer_debug_freeze, second_smbus_timeout_freeze, first_smbus_timeout_freeze,
    general_timer_debug_freeze,
    adv_timer_a_debug_freeze, window_watchdog_debug_freeze, independent_watchdog_debug_freeze} == 9'h000)
    else $error("freeze without halted core");
  bus_off_cause_a: assert property (!bus_clk_en |-> $past(sleep_req || stop_req || pd_req))
    else $error("bus clock off without request");
  sleep_core_a: assert property ($past(sleep_req && !stop_req && !pd_req) |-> core_clk_en && logic_power_on)
    else $error("core clock lost in sleep");
  pd_unpower_a: assert property (!logic_power_on |-> $past(pd_req) && !core_clk_en && !bus_clk_en)
    else $error("bad powered-off state");
  rc_rise_a: assert property ($rose(clk_src_rc) |-> $past(stop_req || pd_req))
    else $error("rc source without stop or pd");
  idle_run_a: assert property ($past(!(sleep_req || stop_req || pd_req)) |->
    core_clk_en && bus_clk_en && logic_power_on)
    else $error("clocks off while idle");
endmodule // lpd_ctrl_chk
bind lpd_ctrl lpd_ctrl_chk u_chk (.mclk, .rst_n, .core_halted, .sleep_req, .stop_req, .pd_req, .in_stop,
  .core_voltage_sel, .adv_timer_b_debug_freeze, .basic_timer_debug_freeze, .lowpower_timer_debug_freeze,
  .second_smbus_timeout_freeze, .first_smbus_timeout_freeze, .general_timer_debug_freeze, .adv_timer_a_debug_freeze,
  .window_watchdog_debug_freeze, .independent_watchdog_debug_freeze, .core_clk_en, .bus_clk_en, .clk_src_rc,
  .logic_power_on);
`default_nettype wire

/* File: sim/lpd_ctrl_test.sv */
// self-checking bench for the low-power debug control block
`timescale 1ns/100ps
`default_nettype none
`include "lpd_consts.vh"
module lpd_ctrl_test;
  logic mclk = 1'b0, rst_n = 1'b0, sys_rst_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic dbg_att = 1'b0, halted = 1'b0, in_stop = 1'b0;
  logic [2:0] req = 3'h0;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  wire [31:0] reg_rdata;
  wire [1:0] vsel;
  wire [8:0] frz;
  wire [3:0] clk_st;
  int bad_count = 0, n_checks = 0, cyc = 0;
  int pos [9] = '{20, 18, 17, 16, 15, 12, 10, 9, 8};
  // debug bits, request, expected {core,bus,rc,power}, compare mask
  logic [15:0] mt [6] = '{16'h019F, 16'h11DF, 16'h021D, 16'h22FF, 16'h040D, 16'h44FF};
  lpd_ctrl dut (.mclk(mclk), .rst_n(rst_n), .sys_rst_n(sys_rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .debugger_attached(dbg_att), .core_halted(halted),
    .sleep_req(req[0]), .stop_req(req[1]), .pd_req(req[2]), .in_stop(in_stop), .core_voltage_sel(vsel),
    .adv_timer_b_debug_freeze(frz[8]), .basic_timer_debug_freeze(frz[7]), .lowpower_timer_debug_freeze(frz[6]),
    .second_smbus_timeout_freeze(frz[5]), .first_smbus_timeout_freeze(frz[4]), .general_timer_debug_freeze(frz[3]),
    .adv_timer_a_debug_freeze(frz[2]), .window_watchdog_debug_freeze(frz[1]),
    .independent_watchdog_debug_freeze(frz[0]), .core_clk_en(clk_st[3]), .bus_clk_en(clk_st[2]),
    .clk_src_rc(clk_st[1]), .logic_power_on(clk_st[0]));
  always #2 mclk = ~mclk;
  // ***************
  // helpers
  // ***************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic sys_pulse;
    @(posedge mclk) sys_rst_n <= 1'b0;
    tick(4);
    @(posedge mclk) sys_rst_n <= 1'b1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test;
    end
  end
  // ***************
  // sequence
  // ***************
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`LPD_OFF_VSEL, 32'h00000007);
    rd(`LPD_OFF_VOVR, 32'h00000000);
    rd(`LPD_OFF_DBG, 32'h00000000);
    rd(6'h3C, 32'h00000000);
    wr(`LPD_OFF_DBG, 32'h00179707);
    rd(`LPD_OFF_DBG, 32'h00000000);
    wr(`LPD_OFF_VOVR, 32'h0000000C);
    wr(`LPD_OFF_VSEL, 32'h0000000F);
    rd(`LPD_OFF_VOVR, 32'h0000000C);
    rd(`LPD_OFF_VSEL, 32'h0000000F);
    @(posedge mclk) in_stop <= 1'b1;
    tick(2);
    check({30'h0, vsel}, 32'h3);
    wr(`LPD_OFF_VSEL, 32'h00000007);
    tick(2);
    check({30'h0, vsel}, 32'h1);
    rd(`LPD_OFF_VSEL, 32'h00000007);
    wr(`LPD_OFF_VSEL, 32'h0000000F);
    wr(`LPD_OFF_VOVR, 32'h00000000);
    tick(2);
    check({30'h0, vsel}, 32'h1);
    @(posedge mclk) in_stop <= 1'b0;
    wr(`LPD_OFF_VOVR, 32'h0000000C);
    sys_pulse;
    rd(`LPD_OFF_VSEL, 32'h0000000F);
    rd(`LPD_OFF_VOVR, 32'h0000000C);
    @(posedge mclk) dbg_att <= 1'b1;
    tick(8);
    wr(`LPD_OFF_DBG, 32'h00179707);
    sys_pulse;
    rd(`LPD_OFF_DBG, 32'h00179707);
    check({23'h0, frz}, 32'h0);
    @(posedge mclk) halted <= 1'b1;
    tick(2);
    check({23'h0, frz}, 32'h1FF);
    for (int i = 0; i < 9; i++) begin
      wr(`LPD_OFF_DBG, 32'h1 << pos[i]);
      tick(2);
      check({23'h0, frz}, {23'h0, 9'h100 >> i});
    end
    @(posedge mclk) halted <= 1'b0;
    tick(2);
    check({23'h0, frz}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(`LPD_OFF_DBG, {29'h0, mt[i][14:12]});
      @(posedge mclk) req <= mt[i][10:8];
      tick(2);
      check({28'h0, clk_st & mt[i][3:0]}, {28'h0, mt[i][7:4]});
      @(posedge mclk) req <= 3'h0;
      tick(2);
      check({28'h0, clk_st}, 32'hD);
    end
    rd(`LPD_OFF_STAT, 32'h00000002);
    wr(`LPD_OFF_STAT, 32'h00000002);
    rd(`LPD_OFF_STAT, 32'h00000000);
    // power reset mid-run clears what a system reset kept
    @(posedge mclk) rst_n <= 1'b0;
    tick(4);
    @(posedge mclk) rst_n <= 1'b1;
    rd(`LPD_OFF_VSEL, 32'h00000007);
    rd(`LPD_OFF_VOVR, 32'h00000000);
    rd(`LPD_OFF_DBG, 32'h00000000);
    finish_test;
  end
endmodule // lpd_ctrl_test
`default_nettype wire
